// ---- tpw_pkg.sv ----
package tpw_pkg;
   localparam logic [7:0] ADDR_TSC      = 8'h00;
   localparam logic [7:0] ADDR_CNT      = 8'h04;
   localparam logic [7:0] ADDR_MOD      = 8'h08;
   localparam logic [7:0] ADDR_CSC0     = 8'h0C;
   localparam logic [7:0] ADDR_CVAL0    = 8'h10;
   localparam logic [7:0] ADDR_CSC1     = 8'h14;
   localparam logic [7:0] ADDR_CVAL1    = 8'h18;
   // timer status/control fields
   localparam int         TSC_PS_LSB    = 0;
   localparam int         TSC_RST_BIT   = 4;
   localparam int         TSC_STOP_BIT  = 5;
   localparam int         TSC_OIE_BIT   = 6;
   localparam int         TSC_OFL_BIT   = 7;
   // channel status/control fields
   localparam int         CSC_MAX_BIT   = 0;
   localparam int         CSC_TOV_BIT   = 1;
   localparam int         CSC_ELA_BIT   = 2;
   localparam int         CSC_ELB_BIT   = 3;
   localparam int         CSC_MSA_BIT   = 4;
   localparam int         CSC_MSB_BIT   = 5;
   localparam int         CSC_IE_BIT    = 6;
   localparam int         CSC_FLG_BIT   = 7;
   localparam logic [15:0] MOD_RESET    = 16'hFFFF;
   localparam logic [2:0]  PS_NONE      = 3'h7;
   localparam int          PRE_W        = 6;
endpackage

// ---- tpw_prescaler.sv ----
`timescale 1ns/1ps
module tpw_prescaler (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clr,
   input  wire logic       run,
   input  wire logic [2:0] sel,
   output logic            tick
);
   typedef struct packed {
      logic [tpw_pkg::PRE_W-1:0] cnt;
   } tpw_pre_st_t;
   tpw_pre_st_t s_q, s_d;
   logic [tpw_pkg::PRE_W-1:0] mask;

   // divide by 2**sel for sel 0 to 6 (sel 7 gives no tick): tick when the low sel bits are all ones
   always_comb begin
      s_d  = s_q;
      mask = tpw_pkg::PRE_W'((7'h01 << sel) - 7'h01);
      tick = run && !clr && (sel != tpw_pkg::PS_NONE) &&
             ((s_q.cnt & mask) == mask); // R25
      if (clr) begin
         s_d.cnt = '0; // R24
      end else if (run) begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- tpw_flag.sv ----
`timescale 1ns/1ps
module tpw_flag (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic set,
   input  wire logic rd_arm,
   input  wire logic wr_zero,
   input  wire logic brk,
   input  wire logic brk_clr_en,
   output logic      flag
);
   // two-step clear: a read with the flag set arms, a 0 write then clears
   typedef struct packed {
      logic flag;
      logic armed;
   } tpw_flg_st_t;
   tpw_flg_st_t s_q, s_d;
   logic        allow;

   always_comb begin
      s_d   = s_q;
      allow = !brk || brk_clr_en; // R21 R22
      if (rd_arm && s_q.flag && allow) begin
         s_d.armed = 1'b1;
      end
      if (wr_zero && s_q.armed && allow) begin
         s_d.flag  = 1'b0; // R23
         s_d.armed = 1'b0;
      end
      // new event wins and cancels a pending clear
      if (set) begin
         s_d.flag  = 1'b1; // R18 R23
         s_d.armed = 1'b0;
      end
      flag = s_q.flag;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- tpw_timer.sv ----
`timescale 1ns/1ps
// Behaviour
// [R1] toggle-on-overflow inverts pin at modulo
// [R2] pulse from overflow until compare match
// [R3] compare drives complement of pulse level
// [R4] period is modulo plus one ticks
// [R5] duty equals compare over period
// [R6] unbuffered compare write takes effect immediately
// [R7] compare irq ends pulse, overflow ends period
// [R8] software times unbuffered width writes
// [R9] software avoids toggle-on-compare for pwm
// [R10] buffered select links channels onto pin 0
// [R11] buffered write switches at next overflow
// [R12] linked: channel 1 unused, pin released
// [R13] software writes only inactive pair
// [R14] software follows initialisation order
// [R15] buffered select beats mode select a
// [R16] no overflow toggle gives zero duty
// [R17] full duty bit with toggle gives 100%
// [R18] flags set on events, enables gate irq
// [R19] counts in wait, bus locked, irq wakes
// [R20] break halts counter, blocks captures
// [R21] break clears only with clear enable
// [R22] armed clear holds through break
// [R23] flag clears by read-set then write-0
// [R24] reset stops counter, reset bit clears
// [R25] prescaler divides by one to 64
// [R26] counter increments and wraps at modulo
module tpw_timer #(
   parameter int CW = 16
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          wait_mode,
   input  wire logic          dbg_break,
   input  wire logic          break_clear_enable,
   input  wire logic [1:0]    cap_in,
   output logic      [1:0]    chan_pin_out,
   output logic      [1:0]    chan_pin_oe,
   output logic               irq,
   output logic               wake
);
   typedef struct packed {
      logic [2:0]    prescale_select;
      logic          counter_stop;
      logic          overflow_irq_en;
      logic [CW-1:0] counter;
      logic [CW-1:0] counter_modulo;
      logic [1:0][6:0] csc;
      logic [1:0][CW-1:0] cval;
      logic [1:0]    pin;
      logic          active1;
      logic          pend1;
      logic          pend0;
      logic [1:0]    cap_q;
      logic [31:0]   rdata;
      logic          rdone;
   } tpw_st_t;
   tpw_st_t s_q, s_d;

   logic          tick, clr, ofl, err;
   logic          acc, wr, rd, locked;
   logic [1:0]    cmp, cap_ev, oc, rd_ch, wz_ch, chf;
   logic          rd_t, wz_t, ovf_flag;
   logic [7:0]    tsc_rd;
   logic [1:0][7:0] csc_rd;
   logic          linked;
   logic [CW-1:0] live0;
   logic [CW-1:0] cnt_nx;

   // registers stay locked in wait; the processor cannot reach them
   assign acc     = psel && penable;
   assign locked  = wait_mode; // R19
   assign wr      = acc && pwrite && !locked;
   assign rd      = acc && !pwrite && !locked && !s_q.rdone;
   // reads take one wait state so the registered data stands at pready
   assign pready  = !(acc && !pwrite && !s_q.rdone);
   assign err     = acc && !(paddr inside {tpw_pkg::ADDR_TSC,
                    tpw_pkg::ADDR_CNT, tpw_pkg::ADDR_MOD,
                    tpw_pkg::ADDR_CSC0, tpw_pkg::ADDR_CVAL0,
                    tpw_pkg::ADDR_CSC1, tpw_pkg::ADDR_CVAL1});
   assign pslverr = err;
   assign prdata  = s_q.rdata;

   assign clr = wr && paddr == tpw_pkg::ADDR_TSC &&
                pwdata[tpw_pkg::TSC_RST_BIT]; // R24

   tpw_prescaler u_pre (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (clr),
      .run     (!s_q.counter_stop && !dbg_break), // R20
      .sel     (s_q.prescale_select),
      .tick    (tick)
   );

   assign linked = s_q.csc[0][tpw_pkg::CSC_MSB_BIT]; // R10 R15
   assign ofl    = tick && s_q.counter == s_q.counter_modulo; // R1 R26
   assign cnt_nx = ofl ? '0 : CW'(s_q.counter + 1'b1);
   // in linked mode channel 0 compares against whichever pair is live
   assign live0  = (linked && s_q.active1) ? s_q.cval[1] : s_q.cval[0];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         logic msa, elb, ela, is_oc;
         logic [CW-1:0] cv;
         assign msa   = s_q.csc[g][tpw_pkg::CSC_MSA_BIT];
         assign elb   = s_q.csc[g][tpw_pkg::CSC_ELB_BIT];
         assign ela   = s_q.csc[g][tpw_pkg::CSC_ELA_BIT];
         assign cv    = (g == 0) ? live0 : s_q.cval[g];
         // channel 1 is dead while linked
         assign is_oc = (g == 0 ? (msa || linked) : (msa && !linked))
                        && (elb || ela); // R12 R15
         assign oc[g] = is_oc;
         // match when the counter reaches cv, so width is cv ticks
         assign cmp[g] = is_oc && tick && cnt_nx == cv; // R2 R5
         // captures use the edges chosen by the edge/level pair
         assign cap_ev[g] = !is_oc && (elb || ela) && !dbg_break &&
                   !(g == 1 && linked) &&
                   ((ela && cap_in[g] && !s_q.cap_q[g]) ||
                    (elb && !cap_in[g] && s_q.cap_q[g])); // R20
         assign rd_ch[g] = rd && paddr == (g == 0 ? tpw_pkg::ADDR_CSC0
                                                   : tpw_pkg::ADDR_CSC1);
         assign wz_ch[g] = wr && paddr == (g == 0 ? tpw_pkg::ADDR_CSC0
                                                   : tpw_pkg::ADDR_CSC1)
                           && !pwdata[tpw_pkg::CSC_FLG_BIT];
         tpw_flag u_chf (
            .pclk       (pclk),
            .presetn    (presetn),
            .set        (cmp[g] || cap_ev[g]), // R18
            .rd_arm     (rd_ch[g]),
            .wr_zero    (wz_ch[g]),
            .brk        (dbg_break),
            .brk_clr_en (break_clear_enable),
            .flag       (chf[g])
         );
         assign csc_rd[g] = {chf[g], s_q.csc[g]};
      end
   endgenerate

   assign rd_t = rd && paddr == tpw_pkg::ADDR_TSC;
   assign wz_t = wr && paddr == tpw_pkg::ADDR_TSC &&
                 !pwdata[tpw_pkg::TSC_OFL_BIT];

   tpw_flag u_tof (
      .pclk       (pclk),
      .presetn    (presetn),
      .set        (ofl), // R18
      .rd_arm     (rd_t),
      .wr_zero    (wz_t),
      .brk        (dbg_break),
      .brk_clr_en (break_clear_enable),
      .flag       (ovf_flag)
   );

   assign tsc_rd = {ovf_flag, s_q.overflow_irq_en, s_q.counter_stop,
                    1'b0, 1'b0, s_q.prescale_select};

   // compare irq at end of pulse, overflow irq at end of period
   assign irq  = (ovf_flag && s_q.overflow_irq_en) ||
                 (chf[0] && s_q.csc[0][tpw_pkg::CSC_IE_BIT]) ||
                 (chf[1] && s_q.csc[1][tpw_pkg::CSC_IE_BIT] &&
                  !linked); // R7 R18
   assign wake = irq && wait_mode; // R19

   always_comb begin
      s_d       = s_q;
      s_d.cap_q = cap_in;
      s_d.rdone = acc && !pwrite && !s_q.rdone;
      // counter
      if (clr) begin
         s_d.counter = '0; // R24
      end else if (tick) begin
         s_d.counter = cnt_nx; // R4 R26
      end
      // buffered pair switches only at overflow
      if (ofl && linked) begin
         if (s_q.pend1) begin
            s_d.active1 = 1'b1; // R11
         end else if (s_q.pend0) begin
            s_d.active1 = 1'b0; // R11
         end
         s_d.pend0 = 1'b0;
         s_d.pend1 = 1'b0;
      end
      if (!linked) begin
         s_d.active1 = 1'b0; // R10
         s_d.pend0   = 1'b0;
         s_d.pend1   = 1'b0;
      end
      // pin actions per channel
      for (int i = 0; i < 2; i++) begin
         if (oc[i]) begin
            if (cmp[i]) begin
               unique case ({s_q.csc[i][tpw_pkg::CSC_ELB_BIT],
                             s_q.csc[i][tpw_pkg::CSC_ELA_BIT]})
                  2'b01: s_d.pin[i] = ~s_q.pin[i];
                  2'b10: s_d.pin[i] = 1'b0; // R3
                  2'b11: s_d.pin[i] = 1'b1; // R3
                  default: s_d.pin[i] = s_q.pin[i];
               endcase
            end
            // overflow toggle applied after the compare action so it defines the period edge
            if (ofl && s_q.csc[i][tpw_pkg::CSC_TOV_BIT]) begin
               s_d.pin[i] = ~s_q.pin[i]; // R1 R16
            end
            if (s_q.csc[i][tpw_pkg::CSC_MAX_BIT] &&
                s_q.csc[i][tpw_pkg::CSC_TOV_BIT]) begin
               s_d.pin[i] = ~s_q.csc[i][tpw_pkg::CSC_ELA_BIT]; // R17
            end
         end else begin
            // initial level while el pair is 00: msa 1 = low
            s_d.pin[i] = ~s_q.csc[i][tpw_pkg::CSC_MSA_BIT];
         end
      end
      // register writes
      if (wr) begin
         unique case (paddr)
            tpw_pkg::ADDR_TSC: begin
               s_d.prescale_select = pwdata[2:0];
               s_d.counter_stop    = pwdata[tpw_pkg::TSC_STOP_BIT];
               s_d.overflow_irq_en = pwdata[tpw_pkg::TSC_OIE_BIT];
            end
            tpw_pkg::ADDR_MOD: s_d.counter_modulo = pwdata[CW-1:0];
            tpw_pkg::ADDR_CSC0: s_d.csc[0] = pwdata[6:0];
            tpw_pkg::ADDR_CSC1: begin
               if (!linked) begin
                  s_d.csc[1] = pwdata[6:0]; // R12
               end
            end
            tpw_pkg::ADDR_CVAL0: begin
               s_d.cval[0] = pwdata[CW-1:0]; // R6
               s_d.pend0   = linked;
               s_d.pend1   = 1'b0;
            end
            tpw_pkg::ADDR_CVAL1: begin
               s_d.cval[1] = pwdata[CW-1:0]; // R6
               s_d.pend1   = linked;
               s_d.pend0   = 1'b0;
            end
            default: ;
         endcase
      end
      // read data registered in access phase
      if (rd) begin
         unique case (paddr)
            tpw_pkg::ADDR_TSC:   s_d.rdata = {24'h000000, tsc_rd};
            tpw_pkg::ADDR_CNT:   s_d.rdata = 32'(s_q.counter);
            tpw_pkg::ADDR_MOD:   s_d.rdata = 32'(s_q.counter_modulo);
            tpw_pkg::ADDR_CSC0:  s_d.rdata = {24'h000000, csc_rd[0]};
            tpw_pkg::ADDR_CSC1:  s_d.rdata = {24'h000000, csc_rd[1]};
            tpw_pkg::ADDR_CVAL0: s_d.rdata = 32'(s_q.cval[0]);
            tpw_pkg::ADDR_CVAL1: s_d.rdata = 32'(s_q.cval[1]);
            default:             s_d.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q                <= '0;
         s_q.counter_stop   <= 1'b1; // R24
         s_q.counter_modulo <= tpw_pkg::MOD_RESET;
         s_q.pin            <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   // channel 1 pin released to general purpose while linked
   assign chan_pin_out = s_q.pin;
   assign chan_pin_oe  = {oc[1], oc[0]}; // R12

   chk_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.counter_stop && !clr |=> s_q.counter == $past(s_q.counter))
      else $error("counter moved while stopped"); // R24
   chk_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
      ofl && !clr |=> s_q.counter == '0)
      else $error("counter did not wrap"); // R26
   chk_brk_halt: assert property (@(posedge pclk) disable iff (!presetn)
      dbg_break && !clr |=> $stable(s_q.counter))
      else $error("counter ran in break"); // R20
   chk_ofl_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ofl |=> ovf_flag)
      else $error("overflow flag missing"); // R18
   chk_tov_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      ofl && oc[0] && s_q.csc[0][tpw_pkg::CSC_TOV_BIT] &&
      !s_q.csc[0][tpw_pkg::CSC_MAX_BIT] && !wr
      |=> s_q.pin[0] != $past(s_q.pin[0]))
      else $error("no toggle on overflow"); // R1
   chk_no_tov: assert property (@(posedge pclk) disable iff (!presetn)
      oc[0] && !s_q.csc[0][tpw_pkg::CSC_TOV_BIT] && s_q.csc[0][3:2] == 2'b10
      && !s_q.pin[0] && !wr |=> !s_q.pin[0])
      else $error("pin rose without overflow toggle"); // R16
   chk_brk_flag: assert property (@(posedge pclk) disable iff (!presetn)
      dbg_break && !break_clear_enable && ovf_flag |=> ovf_flag)
      else $error("flag cleared in break"); // R21
   chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      irq |-> (ovf_flag && s_q.overflow_irq_en) ||
              (chf[0] && s_q.csc[0][6]) || (chf[1] && s_q.csc[1][6]))
      else $error("irq without enabled flag"); // R18
   chk_buf_swap: assert property (@(posedge pclk) disable iff (!presetn)
      linked && s_q.pend1 && ofl && !wr |=> s_q.active1)
      else $error("buffered pair did not switch"); // R11

   cov_ofl:    cover property (@(posedge pclk) ofl);
   cov_cmp:    cover property (@(posedge pclk) cmp[0] ##[1:300] ofl);
   cov_swap:   cover property (@(posedge pclk) linked && s_q.pend1 && ofl);
   cov_brkclr: cover property (@(posedge pclk) dbg_break && wz_t);
endmodule

// ---- tpw_pin_load.sv ----
`timescale 1ns/1ps
module tpw_pin_load (
   input  wire logic       pclk,
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   output logic      [1:0] pin_lvl,
   output int              hi_len,
   output int              lo_len,
   output int              n_edge
);
   int   run  = 0;
   logic last = 1'b1;
   // a released pin floats up to the board pull-up
   assign pin_lvl = (pin_out & pin_oe) | ~pin_oe;
   initial begin
      hi_len = 0;
      lo_len = 0;
      n_edge = 0;
   end
   // level lengths in clocks, recorded when the level ends
   always @(posedge pclk) begin
      if (pin_lvl[0] === last) begin
         run <= run + 1;
      end else begin
         if (last)
            hi_len <= run;
         else
            lo_len <= run;
         run    <= 1;
         last   <= pin_lvl[0];
         n_edge <= n_edge + 1;
      end
   end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        wait_mode, dbg_break, break_clear_enable, irq, wake;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, sv;
   logic [1:0]  cap_in, chan_pin_out, chan_pin_oe, pin_lvl;
   int          hi_len, lo_len, n_edge, e0, n_fail, compares;

   tpw_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wait_mode(wait_mode), .dbg_break(dbg_break),
      .break_clear_enable(break_clear_enable), .cap_in(cap_in),
      .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .irq(irq),
      .wake(wake));
   tpw_pin_load LOAD (.pclk(pclk), .pin_out(chan_pin_out),
      .pin_oe(chan_pin_oe), .pin_lvl(pin_lvl), .hi_len(hi_len),
      .lo_len(lo_len), .n_edge(n_edge));

   task finish_test;
      $display("mismatches %0d, comparisons %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // answer looked at mid-cycle, where it stands settled for the edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic got;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         got = pready;
         err = pslverr;
         rd  = prdata;
         @(posedge pclk);
         n++;
      end while (got !== 1'b1 && n < 16);
      if (got !== 1'b1) begin
         n_fail++;
         finish_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task pwm_setup(input logic [15:0] m, input logic [15:0] c,
                  input logic [7:0] csc, input logic [2:0] ps);
      // stop and reset first, start last; never toggle on compare
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h30);
      apb(1'b1, tpw_pkg::ADDR_MOD, {16'h0, m});
      apb(1'b1, tpw_pkg::ADDR_CVAL0, {16'h0, c});
      apb(1'b1, tpw_pkg::ADDR_CSC0, {24'h0, csc});
      apb(1'b1, tpw_pkg::ADDR_TSC, {29'h0, ps});
      cyc(((int'(m) + 1) * 4) << ps);
   endtask

   task t_reset;
      apb(1'b0, tpw_pkg::ADDR_TSC, 32'h0);
      check(rd[7:0], 8'h20);
      apb(1'b0, tpw_pkg::ADDR_MOD, 32'h0);
      check(rd[15:0], tpw_pkg::MOD_RESET);
      apb(1'b1, 8'hFC, 32'h0);
      check(err, 1'b1);
      apb(1'b0, tpw_pkg::ADDR_CNT, 32'h0);
      check(rd[15:0], 16'h0000);
   endtask

   task t_pwm;
      for (int p = 0; p < 3; p++) begin
         pwm_setup(16'h000F, 16'h0004, 8'h1A, 3'(p));
         check(hi_len, 4 << p);
         check(lo_len, 12 << p);
      end
      pwm_setup(16'h00FF, 16'h0080, 8'h1A, 3'h0);
      check(hi_len, 128);
      check(lo_len, 128);
      apb(1'b0, tpw_pkg::ADDR_CSC0, 32'h0);
      check(rd[7], 1'b1);
      pwm_setup(16'h000F, 16'h0004, 8'h1E, 3'h0);
      check(lo_len, 4);
      check(hi_len, 12);
      apb(1'b1, tpw_pkg::ADDR_CVAL0, 32'hA);
      cyc(48);
      check(lo_len, 10);
   endtask

   task t_const;
      pwm_setup(16'h000F, 16'h0004, 8'h1B, 3'h0);
      e0 = n_edge;
      cyc(40);
      check(n_edge - e0, 0);
      check(pin_lvl[0], 1'b1);
      pwm_setup(16'h000F, 16'h0004, 8'h18, 3'h0);
      e0 = n_edge;
      cyc(40);
      check(n_edge - e0, 0);
   endtask

   task t_buf;
      pwm_setup(16'h000F, 16'h0004, 8'h3A, 3'h0);
      apb(1'b1, tpw_pkg::ADDR_CSC1, 32'h1A);
      check(hi_len, 4);
      check(chan_pin_oe[1], 1'b0);
      apb(1'b1, tpw_pkg::ADDR_CVAL1, 32'h8);
      cyc(48);
      check(hi_len, 8);
      apb(1'b1, tpw_pkg::ADDR_CVAL0, 32'h2);
      cyc(48);
      check(hi_len, 2);
   endtask

   task t_flag;
      pwm_setup(16'h000F, 16'h0004, 8'h1A, 3'h0);
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h40);
      dbg_break <= 1'b1;
      apb(1'b0, tpw_pkg::ADDR_CNT, 32'h0);
      sv = rd;
      cyc(10);
      apb(1'b0, tpw_pkg::ADDR_CNT, 32'h0);
      check(rd, sv);
      dbg_break <= 1'b0;
      // write of zero without a prior read must not clear
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h60);
      apb(1'b0, tpw_pkg::ADDR_TSC, 32'h0);
      check(rd[7:0], 8'hE0);
      check(irq, 1'b1);
      dbg_break <= 1'b1;
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h60);
      apb(1'b0, tpw_pkg::ADDR_TSC, 32'h0);
      check(rd[7], 1'b1);
      dbg_break <= 1'b0;
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h60);
      apb(1'b0, tpw_pkg::ADDR_TSC, 32'h0);
      check(rd[7:0], 8'h60);
      check(irq, 1'b0);
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h40);
      cyc(20);
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h60);
      apb(1'b0, tpw_pkg::ADDR_TSC, 32'h0);
      break_clear_enable <= 1'b1;
      dbg_break          <= 1'b1;
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h60);
      dbg_break <= 1'b0;
      apb(1'b0, tpw_pkg::ADDR_TSC, 32'h0);
      check(rd[7], 1'b0);
      break_clear_enable <= 1'b0;
   endtask

   task t_wait;
      pwm_setup(16'h000F, 16'h0004, 8'h1A, 3'h0);
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h40);
      cyc(20);
      wait_mode <= 1'b1;
      e0 = n_edge;
      cyc(40);
      check(n_edge > e0, 1'b1);
      check(wake, 1'b1);
      apb(1'b1, tpw_pkg::ADDR_TSC, 32'h60);
      wait_mode <= 1'b0;
      apb(1'b0, tpw_pkg::ADDR_TSC, 32'h0);
      check(rd[5], 1'b0);
   endtask

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial begin
      repeat (100000) @(posedge pclk);
      n_fail++;
      finish_test();
   end

   initial begin
      n_fail = 0;
      compares = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wait_mode = 1'b0;
      dbg_break = 1'b0;
      break_clear_enable = 1'b0;
      cap_in = 2'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_pwm();
      t_const();
      t_buf();
      t_flag();
      t_wait();
      finish_test();
   end
endmodule
